// file: fault_consts.svh
// numeric constants for the access fault code generator
`ifndef FAULT_CONSTS_SVH
`define FAULT_CONSTS_SVH

// primary codes and supplements
`define CODE_DELAY_SVC 16'h1A4F
`define CODE_ABS_WORD 16'h1A50
`define CODE_ABS_DWORD 16'h1A51
`define CODE_LIN_BYTE 16'h1A52
`define CODE_LIN_WORD 16'h1A53
`define CODE_LIN_DWORD 16'h1A54
`define CODE_PAGE_BYTE 16'h1A55
`define CODE_PAGE_WORD 16'h1A56
`define CODE_PAGE_DWORD 16'h1A57
`define CODE_MOVE_SRC 16'h1A58
`define CODE_MOVE_DST 16'h1A59
`define CODE_TO_USER 16'h1E23
`define CODE_TO_OUT_IMAGE 16'h1E25
`define CODE_TO_IN_IMAGE 16'h1E26
`define CODE_TO_IPC_IN 16'h1E27
`define CODE_TO_IPC_OUT 16'h1E28
`define CODE_ADDR_FAULT 16'h1E40
`define SUB_BAD_FUNCTION 16'h0001
`define SUB_BAD_DELAY 16'h0002
`define SUB_NONE 16'h0000

// address limits, 17 bits so a carry out of the sum compares as too high
`define LIM_ABS_WORD 17'h0EDFF
`define LIM_ABS_DWORD 17'h0EDFE
`define LIM_LIN_BYTE 17'h0EFFF
`define LIM_LIN_WORD 17'h0EFFE
`define LIM_LIN_DWORD 17'h0EFFC
`define LIM_PAGE_LOW 17'h0F400
`define LIM_PAGE_BYTE 17'h0FFFF
`define LIM_PAGE_WORD 17'h0FFFE
`define LIM_PAGE_DWORD 17'h0FBFC

// memory area starts and top of memory
`define AREA_DB_RAM 17'h08000
`define AREA_DB_ZERO 17'h0DD80
`define AREA_S_FLAGS 17'h0E400
`define AREA_SYS_DATA 17'h0E800
`define AREA_FLAGS_IMAGE 17'h0EE00
`define AREA_PERIPH 17'h0F000
`define AREA_TOP 17'h0FFFF

`define ZERO_WORD 16'h0000
`define ONE_ADDR 17'h00001

`endif

// file: fault_pkg.sv
// types shared by the access fault code generator
package fault_pkg;

  typedef enum logic [3:0] {
    ACC_ABS_WORD,
    ACC_ABS_DWORD,
    ACC_LIN_BYTE,
    ACC_LIN_WORD,
    ACC_LIN_DWORD,
    ACC_LIN_TAS,
    ACC_PAGE_BYTE,
    ACC_PAGE_WORD,
    ACC_PAGE_DWORD,
    ACC_PAGE_TAS,
    ACC_WORD_MOVE,
    ACC_BYTE_MOVE
  } access_kind_t;

  typedef enum logic [2:0] {
    TO_USER,
    TO_OUT_IMAGE,
    TO_IN_IMAGE,
    TO_IPC_IN,
    TO_IPC_OUT
  } timeout_src_t;

  typedef enum logic [2:0] {
    H_NONE,
    H_RUNTIME,
    H_TIMEOUT,
    H_IMAGE_TIMEOUT,
    H_ADDR_FAULT
  } handler_t;

  typedef enum logic [3:0] {
    OP_NONE,
    OP_IRQ_MASK_LOAD,
    OP_IRQ_MASK_SET,
    OP_IRQ_BLOCK_END,
    OP_ADDR_FAULT_IRQ_DISABLE,
    OP_ADDR_FAULT_IRQ_ENABLE,
    OP_REQ_IRQ_ENABLE,
    OP_REQ_IRQ_DISABLE,
    OP_OTHER
  } opcode_t;

  typedef enum logic [2:0] {
    AR_USER,
    AR_DB_RAM,
    AR_DB_ZERO,
    AR_S_FLAGS,
    AR_SYS_DATA,
    AR_FLAGS_IMAGE,
    AR_PERIPH
  } area_t;

endpackage

// file: area_if.sv
// range pair handed to the area decoder and its verdict
`timescale 1ns/1ps
`default_nettype none
interface area_if;
  logic [16:0] lo;
  logic [16:0] hi;
  logic same;
  modport requester (output lo, output hi, input same);
  modport decoder (input lo, input hi, output same);
endinterface
`default_nettype wire

// file: area_decoder.sv
// decides whether an address range sits inside one memory area
`timescale 1ns/1ps
`default_nettype none
`include "fault_consts.svh"
module area_decoder (
  area_if.decoder rng
);
  import fault_pkg::*;

  function automatic area_t area_of(input logic [16:0] a);
    area_t r;
    r = AR_USER;
    if (a >= `AREA_PERIPH) begin
      r = AR_PERIPH;
    end else if (a >= `AREA_FLAGS_IMAGE) begin
      r = AR_FLAGS_IMAGE; // RULE_08
    end else if (a >= `AREA_SYS_DATA) begin
      r = AR_SYS_DATA;
    end else if (a >= `AREA_S_FLAGS) begin
      r = AR_S_FLAGS;
    end else if (a >= `AREA_DB_ZERO) begin
      r = AR_DB_ZERO;
    end else if (a >= `AREA_DB_RAM) begin
      r = AR_DB_RAM; // RULE_07
    end
    return r;
  endfunction

  // range past the top of memory or reversed never counts as one area
  assign rng.same = (rng.hi <= `AREA_TOP) && (rng.hi >= rng.lo) &&
                    (area_of(rng.lo) == area_of(rng.hi)); // RULE_07
endmodule
`default_nettype wire

// file: access_fault_code_generator.sv
// fault detection and error-code generation for memory and bus accesses
// Functional notes
// RULE_01: abs word access faults 1A50H when base plus constant exceeds EDFFH.
// RULE_02: abs double-word access faults 1A51H when address exceeds EDFEH.
// RULE_03: linear byte/word/dword max EFFF/EFFE/EFFC, codes 1A52H/1A53H/1A54H.
// RULE_04: page accesses start at F400H; per-width bound, codes 1A55H-1A57H.
// RULE_05: block move source must lie in one memory area, else 1A58H.
// RULE_06: block move destination must lie in one area, else 1A59H.
// RULE_07: areas start at 0, 8000, DD80, E400, E800, EE00, F000, ending FFFF.
// RULE_08: EE00 through EFFF is one area of flags and process image.
// RULE_09: user peripheral timeout is 1E23H, address second, timeout handler.
// RULE_10: output image timeout gives 1E25H with byte address, image handler.
// RULE_11: input image timeout gives 1E26H with the byte address.
// RULE_12: interprocessor input flag timeout gives 1E27H with flag address.
// RULE_13: interprocessor output flag timeout gives 1E28H with flag address.
// RULE_14: user addressing fault is 1E40H, address second, addressing handler.
// RULE_15: delay service bad function number gives 1A4FH with 0001H.
// RULE_16: delay service bad delay time gives 1A4FH with 0002H.
// RULE_17: mask load/set, block end, fault irq, request irq opcodes not run.
// RULE_18: primary code in first code word, supplement in second, handler.
// RULE_19: an access failing its range or area check is never performed.
`timescale 1ns/1ps
`default_nettype none
`include "fault_consts.svh"
module access_fault_code_generator #(
  parameter logic [15:0] MAX_FUNCTION = 16'h0002,
  parameter logic [15:0] MAX_DELAY = 16'hFFFF
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // access check requests
  input wire logic acc_valid_i,
  output logic acc_ready_o,
  input wire fault_pkg::access_kind_t acc_kind_i,
  input wire logic [15:0] base_pointer_i,
  input wire logic [15:0] offset_i,
  input wire logic [15:0] move_dst_i,
  input wire logic [15:0] move_len_i,
  // go-ahead for accesses that passed
  output logic access_go_o,
  output fault_pkg::access_kind_t access_kind_o,
  output logic [15:0] access_addr_o,
  output logic [15:0] access_dst_o,
  output logic [15:0] access_len_o,
  // bus acknowledge timeouts and addressing faults
  input wire logic acknowledge_timeout_i,
  input wire fault_pkg::timeout_src_t timeout_src_i,
  input wire logic [15:0] timeout_addr_i,
  input wire logic addressing_fault_i,
  input wire logic [15:0] fault_addr_i,
  output logic bus_ready_o,
  // delay-interrupt service arguments
  input wire logic delay_valid_i,
  output logic delay_ready_o,
  input wire logic [15:0] delay_function_i,
  input wire logic [15:0] delay_time_i,
  output logic delay_go_o,
  // opcode screening
  input wire logic op_valid_i,
  output logic op_ready_o,
  input wire fault_pkg::opcode_t opcode_i,
  output logic op_execute_o,
  output logic op_suppressed_o,
  // fault report
  output logic fault_o,
  output logic [15:0] primary_code_word_o,
  output logic [15:0] secondary_code_word_o,
  output fault_pkg::handler_t handler_o
);
  import fault_pkg::*;

  area_if src_rng ();
  area_if dst_rng ();

  area_decoder u_src_dec (
    .rng(src_rng)
  );

  area_decoder u_dst_dec (
    .rng(dst_rng)
  );

  logic [16:0] eff_addr;
  logic [16:0] len_ext;
  logic [16:0] dst_ext;
  logic is_move;
  logic bus_event;
  logic acc_take;
  logic delay_take;
  logic op_take;
  logic acc_bad;
  logic [15:0] acc_code;
  logic delay_bad;
  logic [15:0] delay_sub;
  logic op_blocked;
  logic next_fault;
  logic [15:0] next_primary;
  logic [15:0] next_secondary;
  handler_t next_handler;

  assign eff_addr = {1'b0, base_pointer_i} + {1'b0, offset_i};
  assign len_ext = {1'b0, move_len_i};
  assign dst_ext = {1'b0, move_dst_i};
  assign is_move = (acc_kind_i == ACC_WORD_MOVE) ||
                   (acc_kind_i == ACC_BYTE_MOVE);

  // a move covers start through start plus length minus one; length zero covers start alone
  assign src_rng.lo = eff_addr;
  assign src_rng.hi = (move_len_i == `ZERO_WORD) ? eff_addr :
                      eff_addr + len_ext - `ONE_ADDR; // RULE_05
  assign dst_rng.lo = dst_ext;
  assign dst_rng.hi = (move_len_i == `ZERO_WORD) ? dst_ext :
                      dst_ext + len_ext - `ONE_ADDR; // RULE_06

  // one report per cycle: bus events, then accesses, service, opcodes
  assign bus_event = acknowledge_timeout_i || addressing_fault_i;
  assign bus_ready_o = 1'b1;
  assign acc_ready_o = !bus_event;
  assign delay_ready_o = !bus_event && !acc_valid_i;
  assign op_ready_o = !bus_event && !acc_valid_i && !delay_valid_i;
  assign acc_take = acc_valid_i && acc_ready_o;
  assign delay_take = delay_valid_i && delay_ready_o;
  assign op_take = op_valid_i && op_ready_o;

  // range and area checks
  always_comb begin
    acc_bad = 1'b0;
    acc_code = `ZERO_WORD;
    case (acc_kind_i)
      ACC_ABS_WORD: begin
        acc_bad = eff_addr > `LIM_ABS_WORD; // RULE_01
        acc_code = `CODE_ABS_WORD;
      end
      ACC_ABS_DWORD: begin
        acc_bad = eff_addr > `LIM_ABS_DWORD; // RULE_02
        acc_code = `CODE_ABS_DWORD;
      end
      ACC_LIN_BYTE, ACC_LIN_TAS: begin
        acc_bad = eff_addr > `LIM_LIN_BYTE; // RULE_03
        acc_code = `CODE_LIN_BYTE;
      end
      ACC_LIN_WORD: begin
        acc_bad = eff_addr > `LIM_LIN_WORD; // RULE_03
        acc_code = `CODE_LIN_WORD;
      end
      ACC_LIN_DWORD: begin
        acc_bad = eff_addr > `LIM_LIN_DWORD; // RULE_03
        acc_code = `CODE_LIN_DWORD;
      end
      ACC_PAGE_BYTE, ACC_PAGE_TAS: begin
        acc_bad = (eff_addr < `LIM_PAGE_LOW) ||
                  (eff_addr > `LIM_PAGE_BYTE); // RULE_04
        acc_code = `CODE_PAGE_BYTE;
      end
      ACC_PAGE_WORD: begin
        acc_bad = (eff_addr < `LIM_PAGE_LOW) ||
                  (eff_addr > `LIM_PAGE_WORD); // RULE_04
        acc_code = `CODE_PAGE_WORD;
      end
      ACC_PAGE_DWORD: begin
        acc_bad = (eff_addr < `LIM_PAGE_LOW) ||
                  (eff_addr > `LIM_PAGE_DWORD); // RULE_04
        acc_code = `CODE_PAGE_DWORD;
      end
      ACC_WORD_MOVE, ACC_BYTE_MOVE: begin
        // source is checked first and wins when both are wrong
        if (!src_rng.same) begin
          acc_bad = 1'b1; // RULE_05
          acc_code = `CODE_MOVE_SRC;
        end else if (!dst_rng.same) begin
          acc_bad = 1'b1; // RULE_06
          acc_code = `CODE_MOVE_DST;
        end
      end
      default: begin
        acc_bad = 1'b0;
        acc_code = `ZERO_WORD;
      end
    endcase
  end

  // delay-interrupt service arguments; function is a signed number
  always_comb begin
    delay_bad = 1'b0;
    delay_sub = `SUB_NONE;
    if (delay_function_i[15] || (delay_function_i == `ZERO_WORD) ||
        (delay_function_i > MAX_FUNCTION)) begin
      delay_bad = 1'b1; // RULE_15
      delay_sub = `SUB_BAD_FUNCTION;
    end else if ((delay_time_i == `ZERO_WORD) ||
                 (delay_time_i > MAX_DELAY)) begin
      delay_bad = 1'b1; // RULE_16
      delay_sub = `SUB_BAD_DELAY;
    end
  end

  // opcodes this processor does not carry out
  always_comb begin
    case (opcode_i)
      OP_IRQ_MASK_LOAD, OP_IRQ_MASK_SET, OP_IRQ_BLOCK_END,
      OP_ADDR_FAULT_IRQ_DISABLE, OP_ADDR_FAULT_IRQ_ENABLE,
      OP_REQ_IRQ_ENABLE, OP_REQ_IRQ_DISABLE: begin
        op_blocked = 1'b1; // RULE_17
      end
      default: begin
        op_blocked = 1'b0;
      end
    endcase
  end

  // fault selection
  always_comb begin
    next_fault = 1'b0;
    next_primary = primary_code_word_o;
    next_secondary = secondary_code_word_o;
    next_handler = handler_o;
    if (acknowledge_timeout_i) begin
      next_fault = 1'b1;
      next_secondary = timeout_addr_i; // RULE_18
      next_handler = H_TIMEOUT;
      case (timeout_src_i)
        TO_USER: begin
          next_primary = `CODE_TO_USER; // RULE_09
        end
        TO_OUT_IMAGE: begin
          next_primary = `CODE_TO_OUT_IMAGE; // RULE_10
          next_handler = H_IMAGE_TIMEOUT;
        end
        TO_IN_IMAGE: begin
          next_primary = `CODE_TO_IN_IMAGE; // RULE_11
        end
        TO_IPC_IN: begin
          next_primary = `CODE_TO_IPC_IN; // RULE_12
        end
        TO_IPC_OUT: begin
          next_primary = `CODE_TO_IPC_OUT; // RULE_13
        end
        default: begin
          next_primary = `CODE_TO_USER;
        end
      endcase
    end else if (addressing_fault_i) begin
      next_fault = 1'b1;
      next_primary = `CODE_ADDR_FAULT; // RULE_14
      next_secondary = fault_addr_i; // RULE_14
      next_handler = H_ADDR_FAULT;
    end else if (acc_take && acc_bad) begin
      next_fault = 1'b1;
      next_primary = acc_code; // RULE_18
      next_secondary = `SUB_NONE;
      next_handler = H_RUNTIME;
    end else if (delay_take && delay_bad) begin
      next_fault = 1'b1;
      next_primary = `CODE_DELAY_SVC; // RULE_15
      next_secondary = delay_sub; // RULE_16
      next_handler = H_RUNTIME;
    end
  end

  // fault report; code words hold until the next fault
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      fault_o <= 1'b0;
      primary_code_word_o <= `ZERO_WORD;
      secondary_code_word_o <= `ZERO_WORD;
      handler_o <= H_NONE;
    end else begin
      fault_o <= next_fault; // RULE_18
      primary_code_word_o <= next_primary;
      secondary_code_word_o <= next_secondary;
      handler_o <= next_handler;
    end
  end

  // go-ahead only for a checked access that passed
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      access_go_o <= 1'b0;
      access_kind_o <= ACC_ABS_WORD;
      access_addr_o <= `ZERO_WORD;
      access_dst_o <= `ZERO_WORD;
      access_len_o <= `ZERO_WORD;
    end else begin
      access_go_o <= acc_take && !acc_bad; // RULE_19
      if (acc_take && !acc_bad) begin
        access_kind_o <= acc_kind_i;
        access_addr_o <= eff_addr[15:0];
        access_dst_o <= is_move ? move_dst_i : `ZERO_WORD;
        access_len_o <= is_move ? move_len_i : `ZERO_WORD;
      end
    end
  end

  // service go-ahead and opcode screening
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      delay_go_o <= 1'b0;
      op_execute_o <= 1'b0;
      op_suppressed_o <= 1'b0;
    end else begin
      delay_go_o <= delay_take && !delay_bad;
      op_execute_o <= op_take && !op_blocked; // RULE_17
      op_suppressed_o <= op_take && op_blocked; // RULE_17
    end
  end

endmodule
`default_nettype wire

// file: access_fault_properties.sv
// concurrent checks on the ports of the access fault code generator
`timescale 1ns/1ps
`default_nettype none
module access_fault_properties (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // requests and bus events
  input wire logic acc_valid_i,
  input wire logic acc_ready_o,
  input wire fault_pkg::access_kind_t acc_kind_i,
  input wire logic [15:0] base_pointer_i,
  input wire logic [15:0] offset_i,
  input wire logic acknowledge_timeout_i,
  input wire fault_pkg::timeout_src_t timeout_src_i,
  input wire logic [15:0] timeout_addr_i,
  input wire logic addressing_fault_i,
  input wire logic [15:0] fault_addr_i,
  input wire logic delay_valid_i,
  input wire logic delay_ready_o,
  input wire logic [15:0] delay_function_i,
  input wire logic op_valid_i,
  input wire logic op_ready_o,
  input wire fault_pkg::opcode_t opcode_i,
  // results
  input wire logic access_go_o,
  input wire logic [15:0] access_addr_o,
  input wire logic op_execute_o,
  input wire logic op_suppressed_o,
  input wire logic fault_o,
  input wire logic [15:0] primary_code_word_o,
  input wire logic [15:0] secondary_code_word_o,
  input wire fault_pkg::handler_t handler_o
);
  import fault_pkg::*;
  logic [16:0] eff;
  logic took;
  // carry kept so a wrapped sum counts as too high
  assign eff = {1'b0, base_pointer_i} + {1'b0, offset_i};
  assign took = acc_valid_i && acc_ready_o;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  AST_ABS_WORD: assert property (took && acc_kind_i == ACC_ABS_WORD &&
    eff > 17'h0EDFF |=> fault_o && primary_code_word_o == 16'h1A50 &&
    handler_o == H_RUNTIME) else $error("abs word range fault missing");
  AST_LIN_DWORD: assert property (took && acc_kind_i == ACC_LIN_DWORD &&
    eff > 17'h0EFFC |=> fault_o && primary_code_word_o == 16'h1A54)
    else $error("linear dword range fault missing");
  AST_PAGE_LOW: assert property (took && acc_kind_i == ACC_PAGE_WORD &&
    eff < 17'h0F400 |=> fault_o && primary_code_word_o == 16'h1A56)
    else $error("page low bound fault missing");
  AST_GO_ADDR: assert property (took && acc_kind_i == ACC_LIN_BYTE &&
    eff <= 17'h0EFFF |=> access_go_o && !fault_o &&
    access_addr_o == $past(base_pointer_i) + $past(offset_i))
    else $error("legal access not released with its address");
  AST_TIMEOUT_USER: assert property (acknowledge_timeout_i &&
    timeout_src_i == TO_USER |=> fault_o && primary_code_word_o == 16'h1E23
    && secondary_code_word_o == $past(timeout_addr_i) &&
    handler_o == H_TIMEOUT) else $error("user timeout report wrong");
  AST_ADDR_FAULT: assert property (addressing_fault_i &&
    !acknowledge_timeout_i |=> fault_o && primary_code_word_o == 16'h1E40 &&
    secondary_code_word_o == $past(fault_addr_i) &&
    handler_o == H_ADDR_FAULT) else $error("addressing fault report wrong");
  AST_DELAY_FN: assert property (delay_valid_i && delay_ready_o &&
    $signed(delay_function_i) < 1 |=> fault_o &&
    primary_code_word_o == 16'h1A4F && secondary_code_word_o == 16'h0001)
    else $error("bad function number not refused");
  AST_OP_SUPP: assert property (op_valid_i && op_ready_o && opcode_i
    inside {[OP_IRQ_MASK_LOAD:OP_REQ_IRQ_DISABLE]} |=> op_suppressed_o &&
    !op_execute_o) else $error("unimplemented opcode executed");
  AST_HOLD: assert property (!fault_o |-> $stable(primary_code_word_o) &&
    $stable(secondary_code_word_o)) else $error("code words moved");
endmodule
bind access_fault_code_generator access_fault_properties chk (.*);
`default_nettype wire

// file: backplane_model.sv
// backplane model: an access that no module answers times out
`timescale 1ns/1ps
`default_nettype none
module backplane_model #(
  parameter int WAIT_CYCLES = 3
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // access launched toward an absent module
  input wire logic strobe_i,
  input wire fault_pkg::timeout_src_t src_i,
  input wire logic [15:0] addr_i,
  // timeout event toward the cpu
  output logic acknowledge_timeout_o,
  output fault_pkg::timeout_src_t timeout_src_o,
  output logic [15:0] timeout_addr_o
);
  import fault_pkg::*;
  int cnt;
  logic [15:0] addr;
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt <= 0;
      addr <= 16'h0000;
      timeout_src_o <= TO_USER;
    end else if (strobe_i) begin
      cnt <= WAIT_CYCLES;
      addr <= addr_i;
      timeout_src_o <= src_i;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
    end
  end
  // released address lines show a changed value
  assign acknowledge_timeout_o = (cnt == 1);
  assign timeout_addr_o = (cnt == 1) ? addr : ~addr;
endmodule
`default_nettype wire

// file: test_access_fault_code_generator.sv
// self-checking testbench of the access fault code generator
`timescale 1ns/1ps
`default_nettype none
module test_access_fault_code_generator;
  import fault_pkg::*;
  logic clk_i, reset_n_i, acc_valid_i, addressing_fault_i, strobe;
  logic delay_valid_i, op_valid_i, acknowledge_timeout_i, fault_o;
  logic acc_ready_o, access_go_o, bus_ready_o, delay_ready_o, delay_go_o;
  logic op_ready_o, op_execute_o, op_suppressed_o;
  logic [15:0] base_pointer_i, offset_i, move_dst_i, move_len_i, paddr;
  logic [15:0] fault_addr_i, delay_function_i, delay_time_i, timeout_addr_i;
  logic [15:0] access_addr_o, access_dst_o, access_len_o;
  logic [15:0] primary_code_word_o, secondary_code_word_o;
  access_kind_t acc_kind_i, access_kind_o;
  timeout_src_t timeout_src_i, psrc;
  opcode_t opcode_i;
  handler_t handler_o;
  int n_fail, samples_checked;

  access_fault_code_generator uut (.*);
  backplane_model #(.WAIT_CYCLES(3)) bus (.clk_i(clk_i),
    .reset_n_i(reset_n_i), .strobe_i(strobe), .src_i(psrc), .addr_i(paddr),
    .acknowledge_timeout_o(acknowledge_timeout_i),
    .timeout_src_o(timeout_src_i), .timeout_addr_o(timeout_addr_i));

  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  task summarize;
    $display("checked %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // hold the request until ready, then step past the taking edge
  task take(input int sel);
    int n;
    n = 0;
    #10;
    while ((sel == 0 ? acc_ready_o : sel == 1 ? delay_ready_o : op_ready_o)
           !== 1'b1 && n < 20) begin
      @(negedge clk_i);
      #10;
      n++;
    end
    if (n == 20) begin
      n_fail++;
      summarize();
    end
    @(negedge clk_i);
  endtask

  task rsp(input logic [15:0] code, sec, input handler_t h);
    int n;
    n = 0;
    while (fault_o !== 1'b1 && access_go_o !== 1'b1 && delay_go_o !== 1'b1
           && n < 20) begin
      @(negedge clk_i);
      n++;
    end
    if (n == 20) begin
      n_fail++;
      summarize();
    end
    chk("fault", {15'h0, code != 16'h0000}, {15'h0, fault_o});
    if (code != 16'h0000) begin
      chk("primary", code, primary_code_word_o);
      chk("secondary", sec, secondary_code_word_o);
      if (h != H_NONE) chk("handler", 16'(h), 16'(handler_o));
    end
  endtask

  task acc(input access_kind_t k, input logic [15:0] b, o, d, l, code);
    acc_kind_i = k;
    base_pointer_i = b;
    offset_i = o;
    move_dst_i = d;
    move_len_i = l;
    acc_valid_i = 1'b1;
    take(0);
    chk("go", {15'h0, code == 16'h0000}, {15'h0, access_go_o});
    if (code == 16'h0000) begin
      chk("addr", b + o, access_addr_o);
      chk("kind", 16'(k), 16'(access_kind_o));
      chk("dst", (k == ACC_WORD_MOVE || k == ACC_BYTE_MOVE) ? d : 16'h0000,
          access_dst_o);
      chk("len", (k == ACC_WORD_MOVE || k == ACC_BYTE_MOVE) ? l : 16'h0000,
          access_len_o);
    end
    rsp(code, 16'h0000, H_RUNTIME);
  endtask

  task dly(input logic [15:0] fn, tm, sec);
    delay_function_i = fn;
    delay_time_i = tm;
    delay_valid_i = 1'b1;
    take(1);
    chk("delay go", {15'h0, sec == 16'h0000}, {15'h0, delay_go_o});
    rsp(sec == 16'h0000 ? 16'h0000 : 16'h1A4F, sec, H_RUNTIME);
  endtask

  task t_reset;
    reset_n_i = 1'b0;
    repeat (5) @(negedge clk_i);
    reset_n_i = 1'b1;
    chk("primary", 16'h0000, primary_code_word_o);
    chk("secondary", 16'h0000, secondary_code_word_o);
    chk("handler", 16'(H_NONE), 16'(handler_o));
    chk("go", 16'h0000, {15'h0, access_go_o});
    chk("bus ready", 16'h0001, {15'h0, bus_ready_o});
  endtask

  task t_ranges;
    acc(ACC_ABS_WORD, 16'hED00, 16'h00FF, 0, 0, 0);
    acc(ACC_ABS_WORD, 16'hED00, 16'h0100, 0, 0, 16'h1A50);
    acc(ACC_ABS_WORD, 16'hFFFF, 16'h0002, 0, 0, 16'h1A50);
    acc(ACC_ABS_DWORD, 16'hEDFE, 0, 0, 0, 0);
    acc(ACC_ABS_DWORD, 16'hEDFF, 0, 0, 0, 16'h1A51);
    acc(ACC_LIN_BYTE, 16'hEF00, 16'h00FF, 0, 0, 0);
    acc(ACC_LIN_TAS, 16'hF000, 0, 0, 0, 16'h1A52);
    acc(ACC_LIN_WORD, 16'hEFFF, 0, 0, 0, 16'h1A53);
    acc(ACC_LIN_DWORD, 16'hEFFC, 0, 0, 0, 0);
    acc(ACC_LIN_DWORD, 16'hEFFD, 0, 0, 0, 16'h1A54);
    acc(ACC_PAGE_BYTE, 16'hF3FF, 0, 0, 0, 16'h1A55);
    acc(ACC_PAGE_TAS, 16'hFFFF, 0, 0, 0, 0);
    acc(ACC_PAGE_WORD, 16'hF400, 0, 0, 0, 0);
    acc(ACC_PAGE_WORD, 16'hFFFF, 0, 0, 0, 16'h1A56);
    acc(ACC_PAGE_DWORD, 16'hFBFD, 0, 0, 0, 16'h1A57);
    acc_valid_i = 1'b0;
  endtask

  task t_moves;
    acc(ACC_WORD_MOVE, 16'h7FF0, 0, 0, 16'h0010, 0);
    acc(ACC_WORD_MOVE, 16'h7FF0, 0, 0, 16'h0011, 16'h1A58);
    acc(ACC_BYTE_MOVE, 16'hDD00, 16'h0070, 16'hE3F0, 16'h0010, 0);
    acc(ACC_BYTE_MOVE, 16'hDD00, 16'h0071, 0, 16'h0010, 16'h1A58);
    acc(ACC_WORD_MOVE, 0, 0, 16'hE3F1, 16'h0010, 16'h1A59);
    acc(ACC_WORD_MOVE, 16'hEE00, 0, 16'hE800, 16'h0200, 0);
    acc(ACC_WORD_MOVE, 16'hEDFF, 0, 16'hF000, 16'h0002, 16'h1A58);
    acc(ACC_BYTE_MOVE, 16'hF001, 0, 0, 16'h1000, 16'h1A58);
    acc(ACC_WORD_MOVE, 16'h7FFF, 0, 16'hE3FF, 16'h0002, 16'h1A58);
    acc_valid_i = 1'b0;
  endtask

  task t_timeouts;
    logic [15:0] codes [5];
    handler_t hs [5];
    codes = '{16'h1E23, 16'h1E25, 16'h1E26, 16'h1E27, 16'h1E28};
    hs = '{H_TIMEOUT, H_IMAGE_TIMEOUT, H_TIMEOUT, H_TIMEOUT, H_TIMEOUT};
    for (int i = 0; i < 5; i++) begin
      psrc = timeout_src_t'(i);
      paddr = 16'hF100 + 16'(i);
      strobe = 1'b1;
      @(negedge clk_i);
      strobe = 1'b0;
      rsp(codes[i], 16'hF100 + 16'(i), hs[i]);
      @(negedge clk_i);
    end
    fault_addr_i = 16'h1234;
    addressing_fault_i = 1'b1;
    @(negedge clk_i);
    addressing_fault_i = 1'b0;
    rsp(16'h1E40, 16'h1234, H_ADDR_FAULT);
  endtask

  task t_delay;
    dly(16'h0000, 16'h0000, 16'h0001);
    dly(16'hFFFF, 16'h0005, 16'h0001);
    dly(16'h0003, 16'h0005, 16'h0001);
    dly(16'h0001, 16'h0000, 16'h0002);
    dly(16'h0002, 16'h0005, 16'h0000);
    delay_valid_i = 1'b0;
  endtask

  task t_ops;
    for (int i = 1; i <= 8; i++) begin
      opcode_i = opcode_t'(i);
      op_valid_i = 1'b1;
      take(2);
      chk("suppressed", {15'h0, i < 8}, {15'h0, op_suppressed_o});
      chk("execute", {15'h0, i == 8}, {15'h0, op_execute_o});
      chk("fault", 16'h0000, {15'h0, fault_o});
    end
    op_valid_i = 1'b0;
  endtask

  initial begin
    n_fail = 0;
    samples_checked = 0;
    acc_valid_i = 1'b0;
    acc_kind_i = ACC_ABS_WORD;
    base_pointer_i = 16'h0000;
    offset_i = 16'h0000;
    move_dst_i = 16'h0000;
    move_len_i = 16'h0000;
    addressing_fault_i = 1'b0;
    fault_addr_i = 16'h0000;
    delay_valid_i = 1'b0;
    delay_function_i = 16'h0000;
    delay_time_i = 16'h0000;
    op_valid_i = 1'b0;
    opcode_i = OP_NONE;
    strobe = 1'b0;
    psrc = TO_USER;
    paddr = 16'h0000;
    t_reset();
    t_ranges();
    t_moves();
    t_timeouts();
    t_delay();
    t_ops();
    t_reset();
    summarize();
  end
endmodule
`default_nettype wire
